/* File: iba_arbiter.sv */
// System bus master arbiter, byte lanes and interrupt request front end
`include "iba_params.svh"
module iba_arbiter
   import iba_pkg::*;
#(
   parameter int NM = `IBA_NUM_MASTERS
)
(
   input  wire logic                     clk_in,
   input  wire logic                     nrst_in,
   input  wire logic [NM-1:0]            dev_req_in,
   input  wire logic [NM-1:0]            dev_done_in,
   input  wire logic [`IBA_ADDR_W-1:0]   dev_addr_in,
   input  wire logic [`IBA_ADDR_W+1:0]   dev_len_in,
   input  wire logic                     dev_burst_in,
   input  wire logic                     dev_busy_in,
   input  wire logic                     bus_grant_in,
   input  wire logic                     eisa_refresh_in,
   input  wire logic                     dev_irq_in,
   input  wire logic                     irq_read_in,
   input  wire logic                     dbuf_sel_in,
   input  wire logic [`IBA_ADDR_W-1:0]   bus_addr_in,
   output logic                          bus_req_out,
   output logic [NM-1:0]                 dev_grant_out,
   output logic                          refresh_own_out,
   output logic                          burst_out,
   output logic [1:0]                    txn_type_out,
   output logic [`IBA_ADDR_W-1:0]        addr_out,
   output logic                          addr_oe_n_out,
   output logic [`IBA_ADDR_W-1:0]        addr_seen_out,
   output logic [`IBA_BE_W-1:0]          byte_en_out,
   output logic [1:0]                    lane_out,
   output logic                          dbuf0_oe_n_out,
   output logic                          dbuf1_oe_n_out,
   output logic                          host_irq_out
);

   iba_state_e             state;
   logic [NM-1:0]          next_grant;
   logic [2:0]             grant_s;
   logic [2:0]             refresh_s;
   logic [2:0]             irq_s;
   logic                   irq_seen;
   logic                   own_bus;
   logic [`IBA_ADDR_W+1:0] cur_addr;
   logic [`IBA_ADDR_W+1:0] remain;
   logic                   xfer_go;
   logic                   grant_armed;

   // Three-stage synchronisers; change taken when stages two and three agree
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         grant_s   <= 3'h0;
         refresh_s <= 3'h0;
         irq_s     <= 3'h0;
      end
      else
      begin
         grant_s   <= {grant_s[1:0], bus_grant_in};
         refresh_s <= {refresh_s[1:0], eisa_refresh_in};
         irq_s     <= {irq_s[1:0], dev_irq_in};
      end
   end

   wire grant_ok   = grant_s[1] & grant_s[2];
   wire grant_lost = ~grant_s[1] & ~grant_s[2];
   wire refresh_on = refresh_s[1] & refresh_s[2];
   wire irq_on     = irq_s[1] & irq_s[2];

   // Fixed priority pick, lowest index (LAN) wins
   always_comb
   begin
      next_grant = '0;
      for (int i = NM - 1; i >= 0; i--)
      begin
         if (dev_req_in[i])
         begin
            next_grant = '0;
            next_grant[i] = 1'b1;
         end
      end
   end

   // Bus ownership: one request serves all waiting masters in turn
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
         state <= IBA_IDLE;
      else
      begin
         unique case (state)
            IBA_IDLE:
               if (|dev_req_in)
                  state <= IBA_REQ;
            IBA_REQ:
               if (grant_ok && grant_armed)
                  state <= IBA_OWN;
            IBA_OWN:
               if (grant_lost)
                  state <= (|dev_req_in) ? IBA_REQ : IBA_IDLE;
               else if (!(|dev_req_in) && !(|dev_grant_out))
                  state <= IBA_IDLE;
         endcase
      end
   end

   // A grant counts only once seen low since the request rose; the
   // synchronised grant of the last tenure lingers for a few cycles
   // Limitation: a system arbiter that parks its grant high stalls here
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
         grant_armed <= 1'b0;
      else if (state != IBA_REQ)
         grant_armed <= 1'b0;
      else if (grant_lost)
         grant_armed <= 1'b1;
   end

   // Hold a local grant until that master signals done, the system grant is lost or refresh starts
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
         dev_grant_out <= '0;
      else if (state != IBA_OWN || grant_lost || refresh_on)
         dev_grant_out <= '0;
      else if (|(dev_grant_out & dev_done_in))
         dev_grant_out <= '0;
      else if (!(|dev_grant_out))
         dev_grant_out <= next_grant;
   end

   // Keep the request up while owning so the arbiter sees continued use
   assign bus_req_out     = (state != IBA_IDLE);
   assign refresh_own_out = refresh_on;
   assign own_bus         = (state == IBA_OWN && !grant_lost) || refresh_on;
   assign xfer_go = (|dev_grant_out) & dev_busy_in & (remain != '0);

   // Address walker with byte steps until aligned and for the tail
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         cur_addr <= '0;
         remain   <= '0;
      end
      else if (|next_grant && !(|dev_grant_out) && state == IBA_OWN)
      begin
         cur_addr <= {dev_addr_in, 2'h0};
         remain   <= dev_len_in;
      end
      else if (xfer_go)
      begin
         if (cur_addr[1:0] != 2'h0 || remain < `IBA_WORD_BYTES)
         begin
            cur_addr <= cur_addr + 1'b1;
            remain   <= remain - 1'b1;
         end
         else
         begin
            cur_addr <= cur_addr + `IBA_WORD_BYTES;
            remain   <= remain - `IBA_WORD_BYTES;
         end
      end
   end

   // Byte enables; byte 0 is the top lane, bits 31..24
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         byte_en_out <= '0;
         lane_out    <= 2'h0;
         addr_out    <= '0;
      end
      else if (xfer_go)
      begin
         addr_out <= cur_addr[`IBA_ADDR_W+1:2];
         lane_out <= cur_addr[1:0];
         if (cur_addr[1:0] != 2'h0 || remain < `IBA_WORD_BYTES)
            byte_en_out <= `IBA_BE_LANE0 >> cur_addr[1:0];
         else
            byte_en_out <= `IBA_BE_ALL;
      end
      else
         byte_en_out <= '0;
   end

   // Latch inbound addresses when neither owning the bus nor in refresh
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
         addr_seen_out <= '0;
      else if (!own_bus)
         addr_seen_out <= bus_addr_in;
   end

   // Bus drive enables; only one data buffer set ever drives
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         addr_oe_n_out  <= 1'b1;
         dbuf0_oe_n_out <= 1'b1;
         dbuf1_oe_n_out <= 1'b1;
         burst_out      <= 1'b0;
      end
      else
      begin
         addr_oe_n_out  <= ~(own_bus & (|dev_grant_out));
         dbuf0_oe_n_out <= ~(xfer_go & ~dbuf_sel_in);
         dbuf1_oe_n_out <= ~(xfer_go & dbuf_sel_in);
         burst_out      <= xfer_go & dev_burst_in;
      end
   end

   // Only plain transactions; semaphores and coherent ops never issued
   assign txn_type_out = `IBA_TXN_NORMAL;

   // Single interrupt line, dropped by the read; a new edge wins
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         irq_seen     <= 1'b0;
         host_irq_out <= 1'b0;
      end
      else
      begin
         irq_seen <= irq_on;
         if (irq_on && !irq_seen)
            host_irq_out <= 1'b1;
         else if (irq_read_in)
            host_irq_out <= 1'b0;
      end
   end

   property p_one_buf;
      @(posedge clk_in) disable iff (!nrst_in)
         !(!dbuf0_oe_n_out && !dbuf1_oe_n_out);
   endproperty
   a_one_buf: assert property (p_one_buf) else $error("two buffers");

   property p_one_grant;
      @(posedge clk_in) disable iff (!nrst_in) $onehot0(dev_grant_out);
   endproperty
   a_one_grant: assert property (p_one_grant) else $error("multi grant");

   property p_no_sema;
      @(posedge clk_in) disable iff (!nrst_in)
         txn_type_out == `IBA_TXN_NORMAL;
   endproperty
   a_no_sema: assert property (p_no_sema) else $error("bad txn");

   property p_req_on;
      @(posedge clk_in) disable iff (!nrst_in)
         (state == IBA_IDLE && |dev_req_in) |=> bus_req_out;
   endproperty
   a_req_on: assert property (p_req_on) else $error("no request");

   sequence s_lost;
      state == IBA_OWN ##0 grant_lost ##0 (|dev_req_in);
   endsequence
   property p_rearb;
      @(posedge clk_in) disable iff (!nrst_in)
         s_lost |=> state == IBA_REQ && dev_grant_out == '0;
   endproperty
   a_rearb: assert property (p_rearb) else $error("no rearbitrate");

   property p_prio;
      @(posedge clk_in) disable iff (!nrst_in)
         (state == IBA_OWN && !grant_lost && !refresh_on
          && dev_grant_out == '0 && dev_req_in[0])
         |=> dev_grant_out[0];
   endproperty
   a_prio: assert property (p_prio) else $error("priority");

   property p_refresh;
      @(posedge clk_in) disable iff (!nrst_in)
         refresh_on |=> dev_grant_out == '0;
   endproperty
   a_refresh: assert property (p_refresh) else $error("refresh");

   property p_align;
      @(posedge clk_in) disable iff (!nrst_in)
         (xfer_go && cur_addr[1:0] != 2'h0)
         |=> byte_en_out == (`IBA_BE_LANE0 >> $past(cur_addr[1:0]));
   endproperty
   a_align: assert property (p_align) else $error("alignment");

   property p_irq_drop;
      @(posedge clk_in) disable iff (!nrst_in)
         (irq_read_in && !(irq_on && !irq_seen)) |=> !host_irq_out;
   endproperty
   a_irq_drop: assert property (p_irq_drop) else $error("irq stays");

   // A withdrawn system grant takes the local grant away next cycle
   property p_lost_clear;
      @(posedge clk_in) disable iff (!nrst_in)
         grant_lost |=> dev_grant_out == '0;
   endproperty
   a_lost_clear: assert property (p_lost_clear) else $error("kept");

   // While the system grant holds and no refresh runs, a granted master keeps the bus until it signals done
   property p_grant_hold;
      @(posedge clk_in) disable iff (!nrst_in)
         (state == IBA_OWN && !grant_lost && !refresh_on && |dev_grant_out
          && !(|(dev_grant_out & dev_done_in)))
         |=> $stable(dev_grant_out);
   endproperty
   a_grant_hold: assert property (p_grant_hold) else $error("moved");

   // Burst marking only rides on a transfer step
   property p_burst;
      @(posedge clk_in) disable iff (!nrst_in)
         burst_out |-> (!dbuf0_oe_n_out || !dbuf1_oe_n_out);
   endproperty
   a_burst: assert property (p_burst) else $error("stray burst");

endmodule

/* File: iba_params.svh */
// Constants and rule summary for the I/O subsystem bus master arbiter
// What this block does
// - At most one of the two 32-bit data buffer sets drives the bus.
// - Addresses pass a 30-bit two-way register that drives during master DMA.
// - Byte transfers reach word alignment and finish unaligned transfer ends.
// - Byte 0 sits on bits 31 to 24, byte 3 on bits 7 to 0.
// - Hardware packs bytes into words in order; software reorders commands.
// - One interrupt request for all devices, dropped after interrupt read.
// - No semaphore and no cache-coherent transactions are ever issued.
// - Only single-byte or whole-word byte-enable combinations are issued.
// - Local masters may pipeline and burst on the system bus.
// - Seven local DMA masters gain the bus via request and grant.
// - Simultaneous requests arbitrate once; masters then go by priority.
// - Grant withdrawn means request again before the next DMA transfer.
// - The block masters the bus during EISA refresh cycles.
`ifndef IBA_PARAMS_SVH
`define IBA_PARAMS_SVH
`define IBA_NUM_MASTERS 7
`define IBA_DATA_W      32
`define IBA_ADDR_W      30
`define IBA_BE_W        4
`define IBA_WORD_BYTES  3'h4
`define IBA_BE_LANE0    4'h8
`define IBA_BE_ALL      4'hF
`define IBA_TXN_NORMAL  2'h0
`define IBA_TXN_SEMA    2'h1
`define IBA_TXN_COHER   2'h2
`endif

/* File: iba_pkg.sv */
// Types shared by the bus master arbiter
package iba_pkg;
   typedef enum logic [1:0] {IBA_IDLE, IBA_REQ, IBA_OWN} iba_state_e;
   typedef enum logic [1:0] {IBA_SIZE_BYTE, IBA_SIZE_HALF, IBA_SIZE_WORD}
      iba_size_e;
endpackage

/* File: iba_host_model.sv */
// Behavioural system bus arbiter facing the block's request and grant pins
module iba_host_model
(
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   input  wire logic       bus_req_in,
   input  wire logic       take_in,
   input  wire logic [1:0] lag_in,
   output logic            bus_grant_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_cnt;

   // Grant on the lag_in+1th clock after the request; a withdrawn grant returns once take_in drops
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in || !bus_req_in || take_in)
      begin
         wait_cnt      <= 2'h0;
         bus_grant_out <= 1'b0;
      end
      else if (wait_cnt != lag_in)
         wait_cnt <= wait_cnt + 2'h1;
      else
         bus_grant_out <= 1'b1;
   end
endmodule

/* File: io_system_bus_master_arbiter_bench.sv */
// Self-checking bench for the bus master arbiter
module io_system_bus_master_arbiter_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_in   = 1'b0;
   logic       nrst_in  = 1'b0;
   logic [6:0] req      = 7'h00;
   logic [6:0] done     = 7'h00;
   logic       refresh  = 1'b0;
   logic       irq      = 1'b0;
   logic       irq_read = 1'b0;
   logic       take     = 1'b0;
   logic [1:0] lag      = 2'h0;
   logic [29:0] d_addr    = 30'h0000_0000;
   logic [31:0] d_len     = 32'h0000_0008;
   logic        burst_req = 1'b0;
   logic        sel       = 1'b0;
   logic [29:0] b_addr    = 30'h0000_0000;
   logic       bus_req;
   logic       grant;
   logic [6:0] dev_grant;
   logic       own;
   logic [1:0] txn;
   logic       host_irq;
   logic       a_oe_n;
   logic       d0_oe_n;
   logic       d1_oe_n;
   logic        burst;
   logic [29:0] addr;
   logic [29:0] seen;
   logic [3:0]  be;
   logic [1:0]  lane;
   int         num_errors = 0;
   int         n_tests    = 0;

   iba_arbiter u_dut (.clk_in(clk_in), .nrst_in(nrst_in),
      .dev_req_in(req), .dev_done_in(done), .dev_addr_in(d_addr),
      .dev_len_in(d_len), .dev_burst_in(burst_req), .dev_busy_in(1'b1),
      .bus_grant_in(grant), .eisa_refresh_in(refresh), .dev_irq_in(irq),
      .irq_read_in(irq_read), .dbuf_sel_in(sel),
      .bus_addr_in(b_addr), .bus_req_out(bus_req),
      .dev_grant_out(dev_grant), .refresh_own_out(own), .burst_out(burst),
      .txn_type_out(txn), .addr_out(addr), .addr_oe_n_out(a_oe_n),
      .addr_seen_out(seen), .byte_en_out(be), .lane_out(lane),
      .dbuf0_oe_n_out(d0_oe_n), .dbuf1_oe_n_out(d1_oe_n),
      .host_irq_out(host_irq));

   iba_host_model u_host (.clk_in(clk_in), .nrst_in(nrst_in),
      .bus_req_in(bus_req), .take_in(take), .lag_in(lag),
      .bus_grant_out(grant));

   // Free-running system clock
   initial
   begin
      forever #20 clk_in = ~clk_in;
   end

   task automatic finish_test();
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk_vec(input logic [6:0] got, input logic [6:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %0t vector %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %0t flag %b exp %b", $time, got, exp);
      end
   endtask

   task automatic chk_addr(input logic [29:0] got, input logic [29:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %0t address %h exp %h", $time, got, exp);
      end
   endtask

   // Bounded waits; running out ends the run at once
   task automatic wait_grant(input logic [6:0] exp);
      int i;
      for (i = 0; i < 20 && dev_grant !== exp; i++)
         @(negedge clk_in);
      chk_vec(dev_grant, exp);
      chk_vec({5'h00, txn}, 7'h00);
      if (dev_grant !== exp)
         finish_test();
   endtask

   task automatic wait_flag(input int w, input logic exp);
      int i;
      for (i = 0; i < 20 && (w ? host_irq : own) !== exp; i++)
         @(negedge clk_in);
      chk_bit(w ? host_irq : own, exp);
      if ((w ? host_irq : own) !== exp)
         finish_test();
   endtask

   task automatic release_dev(input logic [6:0] d, input logic [6:0] r);
      done = d;
      req  = r;
      @(negedge clk_in);
      done = 7'h00;
   endtask

   task automatic t_reset();
      chk_bit(bus_req, 1'b0);
      chk_vec(dev_grant, 7'h00);
      chk_bit(host_irq, 1'b0);
      chk_bit(a_oe_n, 1'b1);
      chk_bit(d0_oe_n | d1_oe_n, 1'b1);
      $display("test reset done");
   endtask

   // Three masters at once, served in order on one bus tenure
   task automatic t_priority();
      req = 7'h45;
      repeat (2) @(negedge clk_in);
      chk_bit(bus_req, 1'b1);
      wait_grant(7'h01);
      release_dev(7'h01, 7'h44);
      wait_grant(7'h04);
      chk_bit(grant, 1'b1);
      release_dev(7'h04, 7'h40);
      wait_grant(7'h40);
      chk_bit(d0_oe_n | d1_oe_n, 1'b1);
      release_dev(7'h40, 7'h00);
      wait_grant(7'h00);
      repeat (2) @(negedge clk_in);
      chk_bit(bus_req, 1'b0);
      $display("test priority done");
   endtask

   // Slow arbiter that withdraws the grant mid-transfer
   task automatic t_loss();
      lag = 2'h3;
      req = 7'h08;
      wait_grant(7'h08);
      take = 1'b1;
      wait_grant(7'h00);
      chk_bit(bus_req, 1'b1);
      take = 1'b0;
      wait_grant(7'h08);
      release_dev(7'h08, 7'h00);
      wait_grant(7'h00);
      $display("test loss done");
   endtask

   task automatic t_refresh();
      req = 7'h02;
      wait_grant(7'h02);
      refresh = 1'b1;
      wait_flag(0, 1'b1);
      wait_grant(7'h00);
      refresh = 1'b0;
      wait_flag(0, 1'b0);
      wait_grant(7'h02);
      release_dev(7'h02, 7'h00);
      wait_grant(7'h00);
      $display("test refresh done");
   endtask

   task automatic t_irq();
      irq = 1'b1;
      repeat (3) @(negedge clk_in);
      irq = 1'b0;
      wait_flag(1, 1'b1);
      repeat (5) @(negedge clk_in);
      chk_bit(host_irq, 1'b1);
      irq_read = 1'b1;
      @(negedge clk_in);
      irq_read = 1'b0;
      wait_flag(1, 1'b0);
      // New edge lands in the same cycle as a read: the edge must win
      irq = 1'b1;
      repeat (3) @(negedge clk_in);
      irq      = 1'b0;
      irq_read = 1'b1;
      @(negedge clk_in);
      irq_read = 1'b0;
      chk_bit(host_irq, 1'b1);
      irq_read = 1'b1;
      @(negedge clk_in);
      irq_read = 1'b0;
      wait_flag(1, 1'b0);
      $display("test irq done");
   endtask

   // One word then two tail bytes, burst on buffer set one
   task automatic t_xfer();
      d_addr    = 30'h0000_0100;
      d_len     = 32'h0000_0006;
      burst_req = 1'b1;
      sel       = 1'b1;
      b_addr    = 30'h0ABC_0123;
      repeat (2) @(negedge clk_in);
      chk_addr(seen, 30'h0ABC_0123);
      req = 7'h20;
      wait_grant(7'h20);
      b_addr = 30'h0000_0055;
      @(negedge clk_in);
      chk_vec({3'h0, be}, 7'h0F);
      chk_addr(addr, 30'h0000_0100);
      chk_vec({5'h00, lane}, 7'h00);
      chk_bit(burst, 1'b1);
      chk_bit(d1_oe_n, 1'b0);
      chk_bit(d0_oe_n, 1'b1);
      chk_bit(a_oe_n, 1'b0);
      @(negedge clk_in);
      chk_vec({3'h0, be}, 7'h08);
      chk_addr(addr, 30'h0000_0101);
      @(negedge clk_in);
      chk_vec({3'h0, be}, 7'h04);
      chk_vec({5'h00, lane}, 7'h01);
      @(negedge clk_in);
      chk_vec({3'h0, be}, 7'h00);
      chk_bit(d1_oe_n, 1'b1);
      chk_bit(burst, 1'b0);
      chk_addr(seen, 30'h0ABC_0123);
      release_dev(7'h20, 7'h00);
      wait_grant(7'h00);
      burst_req = 1'b0;
      sel       = 1'b0;
      $display("test xfer done");
   endtask

   // Reset for five cycles, let the synchronisers flush, then run
   initial
   begin
      repeat (5) @(negedge clk_in);
      nrst_in = 1'b1;
      repeat (4) @(negedge clk_in);
      t_reset();
      t_priority();
      t_loss();
      t_refresh();
      t_irq();
      t_xfer();
      finish_test();
   end
endmodule
